// *** hdl/usb_evt_ctrl.sv ***
// usb function event flags, link control, address and transmit control
// assumes the serial engine gives one-cycle event pulses on core_clk
// and answers the host from the handshake and stall outputs below
// Functional notes
// [RULE_01] suspend flag after bus idle over 3 ms
// [RULE_02] idle check armed by reset, paused by sleep
// [RULE_03] dma overrun flag on late service
// [RULE_04] done flag per correct transfer, capture token
// [RULE_05] correct means clean, expected toggle, no nak/stall
// [RULE_06] error flag on timeout, crc, stuffing, framing
// [RULE_07] event overrun when error or sof reset
// [RULE_08] wake flag on activity while suspended
// [RULE_09] usb reset flag, clears address and endpoints
// [RULE_10] sof flag on keep-alive or resume end
// [RULE_11] software clears flags by single store
// [RULE_12] interrupt when flag, mask set, cpu enabled
// [RULE_13] resume bit drives resume onto bus
// [RULE_14] regulator off bit, software waits 3 us
// [RULE_15] sleep bit set by software, cleared by activity
// [RULE_16] clear bit holds reset, flags on release
// [RULE_17] seven-bit function number, cleared on reset
// [RULE_18] status stage bit stalls nonzero out data
// [RULE_19] toggle set by setup, flipped on ack
// [RULE_20] handshake code disabled, stall, nak, valid
// [RULE_21] correct in/setup makes endpoint nak
// [RULE_22] software loads byte count 0 to 8
// [RULE_23] valid endpoints nak while done flag set
// [RULE_24] status write clears zeros, keeps ones
//
// The register addresses and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
module usb_evt_ctrl
#(
	parameter int unsigned SUSPEND_REQUEST_FLAG_IDLE_CYCLES = usb_evt_pkg::SUSPEND_REQUEST_FLAG_IDLE_NS / usb_evt_pkg::CLK_PERIOD_NS
)
(
	input  wire logic                          core_clk,
	input  wire logic                          rst_n,
	// register port
	input  wire logic [usb_evt_pkg::REG_AW-1:0] regAddr,
	input  wire logic [7:0]                    regWdata,
	input  wire logic                          regWr,
	input  wire logic                          regRd,
	output logic      [7:0]                    regRdata,
	// engine events
	input  wire logic                          busIdle,
	input  wire logic                          busActivity,
	input  wire logic                          keepAlive,
	input  wire logic                          resumeEnd,
	input  wire logic                          usbResetSeen,
	input  wire logic                          dmaLate,
	input  wire logic                          errTimeout,
	input  wire logic                          errCrc,
	input  wire logic                          errStuff,
	input  wire logic                          errFrame,
	input  wire logic                          xferEnd,
	input  wire logic [1:0]                    xferToken,
	input  wire logic [1:0]                    xferEp,
	input  wire logic                          xferPidOk,
	input  wire logic                          xferToggleOk,
	input  wire logic                          xferOverrun,
	input  wire logic                          xferSentNak,
	input  wire logic                          xferSentStall,
	input  wire logic                          setupSeen,
	input  wire logic                          hostAck,
	input  wire logic [1:0]                    pktEp,
	input  wire logic                          outNonzero,
	input  wire logic                          cpuIntDisable,
	// answers to the engine and to the chip
	output logic      [1:0]                    inHandshake,
	output logic                               txToggle,
	output logic      [3:0]                    txByteCount,
	output logic                               outStall,
	output logic      [6:0]                    functionNumber,
	output logic                               resumeDrive,
	output logic                               regulatorOff,
	output logic                               suspendActive,
	output logic                               interfaceClear,
	output logic                               usbIrq,
	output logic                               wakeIrq
);
	import usb_evt_pkg::*;

	logic [7:0]  status_q;
	logic [7:0]  status_d;
	logic [7:0]  mask_q;
	logic [3:0]  control_q;
	logic [3:0]  control_d;
	logic [6:0]  funcNum_q;
	logic [7:0]  epTx_q [NUM_EP];
	logic [1:0]  tokenCap_q;
	logic [1:0]  epCap_q;
	logic        suspArm_q;
	logic [31:0] idleCnt_q;
	logic [7:0]  rdata_q;

	wire         wrStatus  = regWr && (regAddr == OFS_STATUS);
	wire         wrMask    = regWr && (regAddr == OFS_MASK);
	wire         wrControl = regWr && (regAddr == OFS_CONTROL);
	wire         wrFuncNum = regWr && (regAddr == OFS_FUNC_NUM);
	wire         sleepBit  = control_q[BIT_SLEEP];
	wire         clearBit  = control_q[BIT_IF_CLEAR];
	wire         doneFlag  = status_q[BIT_DONE];

	// [RULE_16] forced clear acts like bus reset
	wire         ifReset   = usbResetSeen || clearBit;
	// [RULE_16] flag raised when software drops the clear bit
	wire         clearRel  = clearBit && wrControl && !regWdata[BIT_IF_CLEAR];

	// [RULE_05] clean transfer, nak or stall never counts
	wire         correct   = xferEnd && xferPidOk && xferToggleOk && !xferOverrun
	                         && !errCrc && !errStuff && !errFrame
	                         && !xferSentNak && !xferSentStall;
	// [RULE_06] any of the four errors
	wire         errEvt    = errTimeout || errCrc || errStuff || errFrame;
	// [RULE_10] keep-alive or end of resume
	wire         sofEvt    = keepAlive || resumeEnd;
	// [RULE_08] activity only counts while suspended
	wire         wakeEvt   = sleepBit && busActivity;
	// [RULE_01] strictly more than the idle time
	wire         idleOver  = suspArm_q && busIdle && (idleCnt_q == SUSPEND_REQUEST_FLAG_IDLE_CYCLES);
	// [RULE_07] second error or sof before software cleared it
	wire         evtOvr    = (errEvt && status_q[BIT_ERR]) || (sofEvt && status_q[BIT_SOF]);

	// [RULE_03] late dma service sets bit 6
	wire [7:0]   setMask   = {idleOver, dmaLate, correct, errEvt, evtOvr, wakeEvt,
	                          usbResetSeen || clearRel, sofEvt};

	// [RULE_24] zeros clear, ones keep, hardware set wins
	always_comb
	begin
		status_d = status_q;
		if (wrStatus)
		begin
			status_d = status_q & regWdata;
		end
		status_d = status_d | setMask;
	end

	// [RULE_15] activity clears sleep over a software write
	always_comb
	begin
		control_d = control_q;
		if (wrControl)
		begin
			control_d = regWdata[3:0];
		end
		if (busActivity)
		begin
			control_d[BIT_SLEEP] = 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			status_q  <= RST_STATUS;
			mask_q    <= RST_MASK;
			control_q <= RST_CONTROL;
		end
		else
		begin
			status_q  <= status_d;
			control_q <= control_d;
			if (wrMask)
			begin
				mask_q <= regWdata;
			end
		end
	end

	// [RULE_02] armed by each usb reset, paused by sleep until resume ends
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			suspArm_q <= 1'b0;
		end
		else if (ifReset || resumeEnd)
		begin
			suspArm_q <= 1'b1;
		end
		else if (sleepBit)
		begin
			suspArm_q <= 1'b0;
		end
	end

	// [RULE_01] idle counter saturates so the flag is set once per idle spell
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			idleCnt_q <= 32'h0;
		end
		else if (!suspArm_q || !busIdle)
		begin
			idleCnt_q <= 32'h0;
		end
		else if (idleCnt_q <= SUSPEND_REQUEST_FLAG_IDLE_CYCLES)
		begin
			idleCnt_q <= idleCnt_q + 32'h1;
		end
	end

	// [RULE_04] capture held while the done flag stays set
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			tokenCap_q <= 2'h0;
			epCap_q    <= 2'h0;
		end
		else if (correct && !doneFlag)
		begin
			tokenCap_q <= xferToken;
			epCap_q    <= xferEp;
		end
	end

	// [RULE_17] function number, cleared by either reset
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || ifReset)
		begin
			funcNum_q <= RST_FUNC_NUM;
		end
		else if (wrFuncNum)
		begin
			funcNum_q <= regWdata[6:0];
		end
	end

	// endpoint transmit control, one block per endpoint
	for (genvar e = 0; e < NUM_EP; e++)
	begin : g_ep
		wire       hit     = (xferEp == 2'(e));
		wire       wrEp    = regWr && (regAddr == OFS_EP0_TX + 4'(e));
		// [RULE_21] in or setup transfer ends in nak
		wire       goNak   = correct && hit && (xferToken == TOK_IN || xferToken == TOK_SETUP);
		// [RULE_19] setup sets toggle, ack flips it
		wire       setTog  = setupSeen && (pktEp == 2'(e));
		wire       flipTog = hostAck && (pktEp == 2'(e));
		logic [7:0] next;

		always_comb
		begin
			next = epTx_q[e];
			if (wrEp)
			begin
				next = regWdata;
			end
			if (goNak)
			begin
				next[POS_HS +: 2] = HS_NAK;
			end
			if (setTog)
			begin
				next[BIT_TOGGLE] = 1'b1;
			end
			else if (flipTog)
			begin
				next[BIT_TOGGLE] = !epTx_q[e][BIT_TOGGLE];
			end
		end

		// [RULE_09] usb reset returns each endpoint to reset value
		always_ff @(posedge core_clk)
		begin
			if (!rst_n || ifReset)
			begin
				epTx_q[e] <= RST_EP_TX;
			end
			else
			begin
				epTx_q[e] <= next;
			end
		end
	end

	// engine-side answers for the endpoint in the current packet
	wire [7:0]   epSel     = (pktEp < 2'(NUM_EP)) ? epTx_q[pktEp] : 8'h00;
	wire [1:0]   hsRaw     = epSel[POS_HS +: 2];

	// [RULE_23] every valid endpoint naks until done flag clears
	// [RULE_20] handshake code passed through otherwise
	assign inHandshake = (doneFlag && hsRaw == HS_VALID) ? HS_NAK : hsRaw;
	assign txToggle    = epSel[BIT_TOGGLE];
	// [RULE_22] count over 8 is not trapped; software keeps it in range
	assign txByteCount = epSel[3:0];
	// [RULE_18] status stage bit stalls nonzero out data
	assign outStall    = epSel[BIT_STAT_OUT] && outNonzero;

	assign functionNumber = funcNum_q;
	// [RULE_13] resume held until software clears it
	assign resumeDrive    = control_q[BIT_RESUME];
	// [RULE_14] regulator follows the bit; settle time is software's job
	assign regulatorOff   = control_q[BIT_REG_OFF];
	assign suspendActive  = sleepBit;
	assign interfaceClear = ifReset;

	// [RULE_12] flag and mask with cpu interrupts enabled
	wire [7:0]   pend      = status_q & mask_q;
	// [RULE_08] wake event on its own vector so halt can end
	assign wakeIrq = pend[BIT_WAKE] && !cpuIntDisable;
	assign usbIrq  = |(pend & ~(8'h01 << BIT_WAKE)) && !cpuIntDisable;

	// read mux; unmapped offsets read zero
	wire [7:0]   rdMux     =
		(regAddr == OFS_STATUS)         ? status_q :
		(regAddr == OFS_MASK)           ? mask_q :
		(regAddr == OFS_CONTROL)        ? {4'h0, control_q} :
		(regAddr == OFS_FUNC_NUM)       ? {1'b0, funcNum_q} :
		(regAddr == OFS_EP0_TX)         ? epTx_q[0] :
		(regAddr == OFS_EP0_TX + 4'h1)  ? epTx_q[1] :
		(regAddr == OFS_EP0_TX + 4'h2)  ? epTx_q[2] :
		(regAddr == OFS_TOKEN_CAP)      ? {tokenCap_q, 6'h00} :
		(regAddr == OFS_EP_INFO)        ? {2'h0, epCap_q, 4'h0} : 8'h00;

	// read data only stands in the cycle after the strobe
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || !regRd)
		begin
			rdata_q <= 8'h00;
		end
		else
		begin
			rdata_q <= rdMux;
		end
	end

	assign regRdata = rdata_q;
endmodule

// *** shared/usb_evt_pkg.sv ***
// constants for the usb event and transmit control block
// assumes a 25 MHz core clock and an 8-bit register port
package usb_evt_pkg;
	localparam int          CLK_PERIOD_NS  = 40;
	localparam int          SUSPEND_REQUEST_FLAG_IDLE_NS   = 3000000;
	localparam int          REG_AW         = 4;
	localparam int          NUM_EP         = 3;
	// register offsets
	localparam logic [3:0]  OFS_STATUS     = 4'h0;
	localparam logic [3:0]  OFS_MASK       = 4'h1;
	localparam logic [3:0]  OFS_CONTROL    = 4'h2;
	localparam logic [3:0]  OFS_FUNC_NUM   = 4'h3;
	localparam logic [3:0]  OFS_EP0_TX     = 4'h4;
	localparam logic [3:0]  OFS_TOKEN_CAP  = 4'h7;
	localparam logic [3:0]  OFS_EP_INFO    = 4'h8;
	// event status bit positions
	localparam int          BIT_SUSPEND_REQUEST_FLAG       = 7;
	localparam int          BIT_DMA_OVR    = 6;
	localparam int          BIT_DONE       = 5;
	localparam int          BIT_ERR        = 4;
	localparam int          BIT_EVT_OVR    = 3;
	localparam int          BIT_WAKE       = 2;
	localparam int          BIT_USB_RST    = 1;
	localparam int          BIT_SOF        = 0;
	// link control bit positions
	localparam int          BIT_RESUME     = 3;
	localparam int          BIT_REG_OFF    = 2;
	localparam int          BIT_SLEEP      = 1;
	localparam int          BIT_IF_CLEAR   = 0;
	// endpoint transmit control fields
	localparam int          BIT_STAT_OUT   = 7;
	localparam int          BIT_TOGGLE     = 6;
	localparam int          POS_HS         = 4;
	// reset values
	localparam logic [7:0]  RST_STATUS     = 8'h00;
	localparam logic [7:0]  RST_MASK       = 8'h00;
	localparam logic [3:0]  RST_CONTROL    = 4'h6;
	localparam logic [6:0]  RST_FUNC_NUM   = 7'h00;
	localparam logic [7:0]  RST_EP_TX      = 8'h00;
	// handshake states and token kinds
	localparam logic [1:0]  HS_DISABLED    = 2'h0;
	localparam logic [1:0]  HS_STALL       = 2'h1;
	localparam logic [1:0]  HS_NAK         = 2'h2;
	localparam logic [1:0]  HS_VALID       = 2'h3;
	localparam logic [1:0]  TOK_OUT        = 2'h0;
	localparam logic [1:0]  TOK_IN         = 2'h2;
	localparam logic [1:0]  TOK_SETUP      = 2'h3;
endpackage

// *** bench/usb_evt_ctrl_props.sv ***
// port checker for usb_evt_ctrl
// bound to every instance, sees top ports only
`timescale 1ns/1ns
module usb_evt_ctrl_props
(
	input wire logic       core_clk,
	input wire logic       rst_n,
	input wire logic       regWr,
	input wire logic       busActivity,
	input wire logic       usbResetSeen,
	input wire logic       errCrc,
	input wire logic       errStuff,
	input wire logic       errFrame,
	input wire logic       xferEnd,
	input wire logic       xferPidOk,
	input wire logic       xferToggleOk,
	input wire logic       xferOverrun,
	input wire logic       xferSentNak,
	input wire logic       xferSentStall,
	input wire logic       setupSeen,
	input wire logic [1:0] pktEp,
	input wire logic       outNonzero,
	input wire logic       cpuIntDisable,
	input wire logic [1:0] inHandshake,
	input wire logic       txToggle,
	input wire logic [6:0] functionNumber,
	input wire logic       outStall,
	input wire logic       suspendActive,
	input wire logic       interfaceClear,
	input wire logic       usbIrq,
	input wire logic       wakeIrq
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	// clean transfer, no defect of any kind except timeout, which is not looked at
	wire good = xferEnd & xferPidOk & xferToggleOk & ~xferOverrun & ~xferSentNak
		& ~xferSentStall & ~errCrc & ~errStuff & ~errFrame;
	AST_IFCLR: assert property (usbResetSeen |-> interfaceClear)
		else $error("interface clear missing on bus reset");
	AST_FNUM: assert property (usbResetSeen |=> functionNumber == 7'h00)
		else $error("function number kept over bus reset");
	AST_EP: assert property (usbResetSeen && !regWr && !setupSeen
		|=> inHandshake == 2'h0 && !txToggle) else $error("endpoint kept over bus reset");
	AST_CPU: assert property (cpuIntDisable |-> !usbIrq && !wakeIrq)
		else $error("interrupt while cpu disabled");
	AST_OSTALL: assert property (!outNonzero |-> !outStall)
		else $error("zero length out stalled");
	AST_NAK: assert property (good |=> inHandshake != 2'h3)
		else $error("valid handshake after correct transfer");
	AST_WAKE: assert property (busActivity |=> !suspendActive)
		else $error("sleep bit kept over activity");
	AST_TOG: assert property (setupSeen && !interfaceClear && pktEp != 2'h3
		##1 $stable(pktEp) |-> txToggle) else $error("toggle not set by setup");
	cover property (good);
	cover property (setupSeen);
	cover property (usbResetSeen ##1 !usbResetSeen);
endmodule
bind usb_evt_ctrl usb_evt_ctrl_props propsChk (.*);

// *** bench/usb_host_model.sv ***
// host and serial engine side: transfer ends, setup and ack pids
// tasks are called by the bench; signals change after core_clk edges
`timescale 1ns/1ns
module usb_host_model
(
	input  wire logic core_clk,
	output logic       xferEnd,
	output logic [1:0] xferToken,
	output logic [1:0] xferEp,
	output logic       xferPidOk,
	output logic       xferToggleOk,
	output logic       xferOverrun,
	output logic       xferSentNak,
	output logic       xferSentStall,
	output logic       setupSeen,
	output logic       hostAck
);
	initial
	begin
		{xferEnd, xferToken, xferEp, xferPidOk, xferToggleOk} = 7'h00;
		{xferOverrun, xferSentNak, xferSentStall, setupSeen, hostAck} = 5'h00;
	end
	// defect codes: 1 pid, 2 toggle, 3 overrun, 4 nak, 5 stall
	task automatic xfer(input logic [1:0] t, input logic [1:0] e, input logic [2:0] bad);
		@(posedge core_clk);
		xferEnd <= 1'b1;
		xferToken <= t;
		xferEp <= e;
		xferPidOk <= bad != 3'h1;
		xferToggleOk <= bad != 3'h2;
		xferOverrun <= bad == 3'h3;
		xferSentNak <= bad == 3'h4;
		xferSentStall <= bad == 3'h5;
		@(posedge core_clk);
		xferEnd <= 1'b0;
		// released fields must not keep last value
		xferToken <= ~t;
		xferEp <= ~e;
	endtask
	// ack low sends a setup pid, ack high sends an ack pid
	task automatic pid(input logic ack);
		@(posedge core_clk);
		setupSeen <= !ack;
		hostAck <= ack;
		@(posedge core_clk);
		setupSeen <= 1'b0;
		hostAck <= 1'b0;
	endtask
endmodule

// *** bench/usb_evt_ctrl_bench.sv ***
// self-checking bench for usb_evt_ctrl
// short idle count of 20; host model drives transfer fields
`timescale 1ns/1ns
module usb_evt_ctrl_bench;
	import usb_evt_pkg::*;
	localparam logic [7:0] EXP [9] = '{8'h04, 8'h02, 8'h40, 8'h10, 8'h10, 8'h10,
		8'h10, 8'h01, 8'h01};
	localparam logic [3:0] EP1 = OFS_EP0_TX + 4'h1;
	localparam logic [3:0] EP2 = OFS_EP0_TX + 4'h2;
	logic       core_clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       regWr = 1'b0;
	logic       regRd = 1'b0;
	logic       busIdle = 1'b0;
	logic       outNonzero = 1'b0;
	logic       cpuIntDisable = 1'b0;
	logic [1:0] pktEp = 2'h0;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWdata = 8'h00;
	logic [8:0] ev = 9'h000;
	logic [7:0] regRdata;
	logic [1:0] inHandshake, xferToken, xferEp;
	logic [3:0] txByteCount;
	logic [6:0] functionNumber;
	logic       txToggle, outStall, resumeDrive, regulatorOff, suspendActive;
	logic       interfaceClear, usbIrq, wakeIrq, xferEnd, xferPidOk, xferToggleOk;
	logic       xferOverrun, xferSentNak, xferSentStall, setupSeen, hostAck;
	int         badCount = 0;
	int         checked = 0;
	int         cyc = 0;
	usb_evt_ctrl #(.SUSPEND_REQUEST_FLAG_IDLE_CYCLES(20)) dut
	(
		.*,
		.busActivity  (ev[0]),
		.usbResetSeen (ev[1]),
		.dmaLate      (ev[2]),
		.errTimeout   (ev[3]),
		.errCrc       (ev[4]),
		.errStuff     (ev[5]),
		.errFrame     (ev[6]),
		.keepAlive    (ev[7]),
		.resumeEnd    (ev[8])
	);
	usb_host_model host (.*);
	initial
	begin
		forever #20 core_clk = ~core_clk;
	end
	task printVerdict;
		$display("checks %0d mismatches %0d", checked, badCount);
		if (badCount == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ceiling well above the ~330 cycles of the sequence
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 4000)
		begin
			badCount++;
			printVerdict;
		end
	end
	task chk(input logic [7:0] s, input logic [7:0] e);
		checked++;
		if (s !== e)
		begin
			badCount++;
			$display("CHECK FAILED t=%0t seen=%h expected=%h", $time, s, e);
		end
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge core_clk);
		regWr <= 1'b0;
		#1;
	endtask
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge core_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1 chk(regRdata, e);
	endtask
	task pulse(input int b);
		@(posedge core_clk);
		ev <= 9'h001 << b;
		@(posedge core_clk);
		ev <= 9'h000;
		#1;
	endtask
	task step;
		@(posedge core_clk);
		#1;
	endtask
	initial
	begin
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++)
			rd(i[3:0], (i == 2) ? 8'h06 : 8'h00);
		rd(4'hF, 8'h00);
		wr(OFS_MASK, 8'hFF);
		for (int i = 0; i < 9; i++)
		begin
			pulse(i);
			chk(usbIrq, i != 0);
			chk(wakeIrq, i == 0);
			rd(OFS_STATUS, EXP[i]);
			wr(OFS_STATUS, 8'h00);
		end
		chk(suspendActive, 1'b0);
		pulse(4);
		pulse(4);
		rd(OFS_STATUS, 8'h18);
		// single store keeps ones, clears zeros
		wr(OFS_STATUS, 8'hEF);
		rd(OFS_STATUS, 8'h08);
		wr(OFS_STATUS, 8'hFF);
		rd(OFS_STATUS, 8'h08);
		wr(OFS_CONTROL, 8'hF8);
		rd(OFS_CONTROL, 8'h08);
		chk({resumeDrive, regulatorOff}, 2'h2);
		// regulator settling before further use
		repeat (75) @(posedge core_clk);
		wr(OFS_FUNC_NUM, 8'hD5);
		rd(OFS_FUNC_NUM, 8'h55);
		chk(functionNumber, 7'h55);
		wr(OFS_EP0_TX, 8'h3F);
		pulse(1);
		rd(OFS_FUNC_NUM, 8'h00);
		rd(OFS_EP0_TX, 8'h00);
		wr(OFS_STATUS, 8'h00);
		wr(OFS_CONTROL, 8'h01);
		chk(interfaceClear, 1'b1);
		wr(OFS_FUNC_NUM, 8'h11);
		rd(OFS_FUNC_NUM, 8'h00);
		wr(OFS_CONTROL, 8'h00);
		rd(OFS_STATUS, 8'h02);
		wr(OFS_STATUS, 8'h00);
		busIdle <= 1'b1;
		repeat (12) @(posedge core_clk);
		rd(OFS_STATUS, 8'h00);
		repeat (10) @(posedge core_clk);
		rd(OFS_STATUS, 8'h80);
		busIdle <= 1'b0;
		wr(OFS_STATUS, 8'h00);
		wr(OFS_CONTROL, 8'h02);
		busIdle <= 1'b1;
		repeat (30) @(posedge core_clk);
		rd(OFS_STATUS, 8'h00);
		busIdle <= 1'b0;
		pulse(0);
		rd(OFS_STATUS, 8'h04);
		wr(OFS_STATUS, 8'h00);
		pktEp <= 2'h1;
		wr(EP1, 8'h35);
		chk({inHandshake, txByteCount}, 6'h35);
		for (int b = 1; b < 6; b++)
		begin
			host.xfer(TOK_IN, 2'h1, b[2:0]);
			rd(OFS_STATUS, 8'h00);
		end
		host.xfer(TOK_IN, 2'h1, 3'h0);
		rd(OFS_STATUS, 8'h20);
		chk(inHandshake, HS_NAK);
		chk(usbIrq, 1'b1);
		cpuIntDisable <= 1'b1;
		step;
		chk(usbIrq, 1'b0);
		cpuIntDisable <= 1'b0;
		rd(OFS_TOKEN_CAP, 8'h80);
		rd(OFS_EP_INFO, 8'h10);
		pktEp <= 2'h2;
		wr(EP2, 8'h30);
		chk(inHandshake, HS_NAK);
		wr(OFS_STATUS, 8'h00);
		for (int h = 0; h < 4; h++)
		begin
			wr(EP2, {2'h0, h[1:0], 4'h0});
			chk(inHandshake, h[1:0]);
		end
		host.pid(1'b0);
		step;
		chk(txToggle, 1'b1);
		host.pid(1'b1);
		step;
		chk(txToggle, 1'b0);
		wr(EP2, 8'h80);
		outNonzero <= 1'b1;
		step;
		chk(outStall, 1'b1);
		outNonzero <= 1'b0;
		step;
		chk(outStall, 1'b0);
		// out transfer keeps tx state, setup forces nak
		wr(EP2, 8'h30);
		host.xfer(TOK_OUT, 2'h2, 3'h0);
		rd(EP2, 8'h30);
		chk(inHandshake, HS_NAK);
		wr(OFS_STATUS, 8'h00);
		host.xfer(TOK_SETUP, 2'h2, 3'h0);
		rd(EP2, 8'h20);
		// capture frozen while done flag stands
		host.xfer(TOK_IN, 2'h1, 3'h0);
		rd(OFS_TOKEN_CAP, 8'hC0);
		rd(OFS_EP_INFO, 8'h20);
		printVerdict;
	end
endmodule
